// ==== rtl/cri_defs.svh ====
// Constants of the clock ready interrupt flag block: offsets, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef CRI_DEFS_SVH
`define CRI_DEFS_SVH

`define CRI_ADDR_W 8
`define CRI_DATA_W 32
`define CRI_STRB_W 4
`define CRI_OFF_CTRL 8'h08
`define CRI_OFF_EVT_STS 8'h20
`define CRI_OFF_EVT_MASK 8'h24
`define CRI_CTRL_RESET 32'h0000_0000
`define CRI_EVT_RESET 6'h00
`define CRI_MASK_RESET 6'h00
`define CRI_NSRC 5
`define CRI_NEVT 6
`define CRI_FLAG_LSB 0
`define CRI_FLAG_MSB 4
`define CRI_CSS_FLAG_BIT 7
`define CRI_EN_LSB 8
`define CRI_EN_MSB 12
`define CRI_CLR_LSB 16
`define CRI_CLR_MSB 20
`define CRI_CSS_CLR_BIT 23
`define CRI_CSS_IDX 5
`define CRI_IDX_PLL 4
`define CRI_IDX_FEXT 3
`define CRI_IDX_FINT 2
`define CRI_IDX_SEXT 1
`define CRI_IDX_SINT 0
`define CRI_EVT_LSB 0
`define CRI_EVT_MSB 5
`define CRI_STRB_FLAG 0
`define CRI_STRB_EN 1
`define CRI_STRB_CLR 2
`define CRI_RESP_OKAY 2'b00
`define CRI_RESP_SLVERR 2'b10

`endif

// ==== rtl/cri_pkg.sv ====
// Types shared by the clock ready interrupt flag block.
// Assumes nothing of its surroundings.
`default_nettype none

package cri_pkg;

   // Raw status levels from the oscillators, PLL and failure detector.
   typedef struct packed {
      logic css_fail;
      logic pll;
      logic fast_ext;
      logic fast_int;
      logic slow_ext;
      logic slow_int;
   } cri_src_t;

   typedef enum logic [1:0] {
      CRI_WR_IDLE = 2'b01,
      CRI_WR_RESP = 2'b10
   } cri_wr_state_t;

   typedef enum logic [1:0] {
      CRI_RD_IDLE = 2'b01,
      CRI_RD_RESP = 2'b10
   } cri_rd_state_t;

endpackage

`default_nettype wire

// ==== rtl/cri_top.sv ====
// Clock ready and clock security interrupt flags with an AXI4-Lite register slave.
// Assumes the status inputs come from other clock domains and are synchronised here.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`include "cri_defs.svh"
`default_nettype none

// Contract
// [R1] PLL ready enable gates PLL ready flag
// [R2] Bit 11 enables fast external ready interrupt
// [R3] Bit 10 enables fast internal ready interrupt
// [R4] Bit 9 enables slow external ready interrupt
// [R5] Bit 8 enables slow internal ready interrupt
// [R6] Bit 7 flags external oscillator failure
// [R7] Software keeps reserved bits 6:5 at reset
// [R8] Bit 4 sets when enabled PLL locks
// [R9] Clear bit 20 clears PLL flag only
// [R10] Bit 3 sets on enabled fast external ready
// [R11] Clear bit 19 clears fast external flag
// [R12] Bit 2 sets on enabled fast internal ready
// [R13] Clear bit 18 clears fast internal flag
// [R14] Bit 1 sets on enabled slow external ready
// [R15] Clear bit 17 clears slow external flag
// [R16] Bit 0 sets on enabled slow internal ready
// [R17] Clear bit 16 clears slow internal flag
// [R18] Clear bit 23 clears security flag
// [R19] Interrupt request while any flag is set
module cri_top (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Oscillator, PLL and failure status levels.
   input wire cri_pkg::cri_src_t osc_status_in,
   // AXI4-Lite write address channel.
   input wire logic [`CRI_ADDR_W-1:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   // AXI4-Lite write data channel.
   input wire logic [`CRI_DATA_W-1:0] wdata_in,
   input wire logic [`CRI_STRB_W-1:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   // AXI4-Lite write response channel.
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   // AXI4-Lite read address channel.
   input wire logic [`CRI_ADDR_W-1:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   // AXI4-Lite read data channel.
   output logic [`CRI_DATA_W-1:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   // Interrupt requests.
   output logic clock_irq_out,
   output logic irq_out
);
   import cri_pkg::*;

   // A literal cannot be sliced, so the control reset image is held here and each field takes its part.
   localparam logic [`CRI_DATA_W-1:0] ctrl_reset_image = `CRI_CTRL_RESET;

   function automatic logic is_mapped(input logic [`CRI_ADDR_W-1:0] addr);
      is_mapped = (addr == `CRI_OFF_CTRL) || (addr == `CRI_OFF_EVT_STS) || (addr == `CRI_OFF_EVT_MASK);
   endfunction

   // Expands byte strobes into a bit mask.
   function automatic logic [`CRI_DATA_W-1:0] strb_mask(input logic [`CRI_STRB_W-1:0] strb);
      logic [`CRI_DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < `CRI_STRB_W; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      strb_mask = m;
   endfunction

   // Synchronisers and edge detection.
   cri_src_t src_s1_q;
   cri_src_t src_s2_q;
   cri_src_t src_s3_q;
   logic [`CRI_NEVT-1:0] src_rise;

   // Register state.
   logic [`CRI_NSRC-1:0] irq_en_q;
   logic [`CRI_NSRC-1:0] ready_flag_q;
   logic [`CRI_NSRC-1:0] ready_flag_d;
   logic clock_security_flag_q;
   logic clock_security_flag_d;
   logic [`CRI_NEVT-1:0] evt_status_q;
   logic [`CRI_NEVT-1:0] evt_status_d;
   logic [`CRI_NEVT-1:0] evt_mask_q;

   // Bus state.
   cri_wr_state_t wr_state_q;
   cri_rd_state_t rd_state_q;
   logic aw_got_q;
   logic w_got_q;
   logic [`CRI_ADDR_W-1:0] wr_addr_q;
   logic [`CRI_DATA_W-1:0] wr_data_q;
   logic [`CRI_STRB_W-1:0] wr_strb_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [`CRI_DATA_W-1:0] rdata_q;
   logic clock_irq_q;
   logic irq_q;

   logic wr_fire;
   logic [`CRI_DATA_W-1:0] wr_bits;
   logic wr_ctrl;
   logic wr_evt_sts;
   logic wr_evt_mask;
   logic [`CRI_NSRC-1:0] flag_set;
   logic [`CRI_NSRC-1:0] flag_clr;
   logic css_set;
   logic css_clr;
   logic [`CRI_DATA_W-1:0] ctrl_view;
   logic [`CRI_NEVT-1:0] evt_mask_d;

   // One name per ready enable, flag and clear field of the control register, in source order.
   logic pll_ready_irq_enable;
   logic fast_ext_osc_ready_irq_enable;
   logic fast_int_osc_ready_irq_enable;
   logic slow_ext_osc_ready_irq_enable;
   logic slow_int_osc_ready_irq_enable;
   logic pll_ready_flag;
   logic fast_ext_osc_ready_flag;
   logic fast_int_osc_ready_flag;
   logic slow_ext_osc_ready_flag;
   logic slow_int_osc_ready_flag;
   logic pll_ready_clear;
   logic fast_ext_osc_ready_clear;
   logic fast_int_osc_ready_clear;
   logic slow_ext_osc_ready_clear;
   logic slow_int_osc_ready_clear;

   // The first stage is read by the second stage only.
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         src_s1_q <= '0;
         src_s2_q <= '0;
         src_s3_q <= '0;
      end else begin
         src_s1_q <= osc_status_in;
         src_s2_q <= src_s1_q;
         src_s3_q <= src_s2_q;
      end
   end

   // A flag is raised when its source becomes ready, not while it stays ready, so a clear sticks.
   assign src_rise = src_s2_q & ~src_s3_q;

   // A write takes effect once both address and data have been accepted.
   assign wr_fire = (wr_state_q == CRI_WR_IDLE) && aw_got_q && w_got_q;
   assign wr_bits = wr_data_q & strb_mask(wr_strb_q);
   assign wr_ctrl = wr_fire && (wr_addr_q == `CRI_OFF_CTRL);
   assign wr_evt_sts = wr_fire && (wr_addr_q == `CRI_OFF_EVT_STS);
   assign wr_evt_mask = wr_fire && (wr_addr_q == `CRI_OFF_EVT_MASK);

   // Ready flags set only while their enable is one; set wins over a clear in the same cycle.
   assign pll_ready_irq_enable = irq_en_q[`CRI_IDX_PLL]; // [R1]
   assign fast_ext_osc_ready_irq_enable = irq_en_q[`CRI_IDX_FEXT]; // [R2]
   assign fast_int_osc_ready_irq_enable = irq_en_q[`CRI_IDX_FINT]; // [R3]
   assign slow_ext_osc_ready_irq_enable = irq_en_q[`CRI_IDX_SEXT]; // [R4]
   assign slow_int_osc_ready_irq_enable = irq_en_q[`CRI_IDX_SINT]; // [R5]
   assign flag_set = src_rise[`CRI_NSRC-1:0] & {pll_ready_irq_enable, fast_ext_osc_ready_irq_enable,
      fast_int_osc_ready_irq_enable, slow_ext_osc_ready_irq_enable,
      slow_int_osc_ready_irq_enable}; // [R8] [R10] [R12] [R14] [R16]

   // Each clear bit sits a fixed distance above its flag; a zero written there leaves the flag alone.
   assign pll_ready_clear = wr_ctrl && wr_bits[`CRI_CLR_LSB + `CRI_IDX_PLL]; // [R9]
   assign fast_ext_osc_ready_clear = wr_ctrl && wr_bits[`CRI_CLR_LSB + `CRI_IDX_FEXT]; // [R11]
   assign fast_int_osc_ready_clear = wr_ctrl && wr_bits[`CRI_CLR_LSB + `CRI_IDX_FINT]; // [R13]
   assign slow_ext_osc_ready_clear = wr_ctrl && wr_bits[`CRI_CLR_LSB + `CRI_IDX_SEXT]; // [R15]
   assign slow_int_osc_ready_clear = wr_ctrl && wr_bits[`CRI_CLR_LSB + `CRI_IDX_SINT]; // [R17]
   assign flag_clr = {pll_ready_clear, fast_ext_osc_ready_clear, fast_int_osc_ready_clear,
      slow_ext_osc_ready_clear, slow_int_osc_ready_clear};
   assign ready_flag_d = flag_set | (ready_flag_q & ~flag_clr);

   assign pll_ready_flag = ready_flag_q[`CRI_IDX_PLL];
   assign fast_ext_osc_ready_flag = ready_flag_q[`CRI_IDX_FEXT];
   assign fast_int_osc_ready_flag = ready_flag_q[`CRI_IDX_FINT];
   assign slow_ext_osc_ready_flag = ready_flag_q[`CRI_IDX_SEXT];
   assign slow_int_osc_ready_flag = ready_flag_q[`CRI_IDX_SINT];

   // The failure flag does not depend on any enable held here.
   assign css_set = src_rise[`CRI_CSS_IDX]; // [R6]
   assign css_clr = wr_ctrl && wr_bits[`CRI_CSS_CLR_BIT]; // [R18]
   assign clock_security_flag_d = css_set || (clock_security_flag_q && !css_clr);

   assign evt_status_d = {css_set, flag_set} | (evt_status_q & ~(wr_evt_sts ? wr_bits[`CRI_EVT_MSB:`CRI_EVT_LSB] : '0));

   // The masked request follows the next mask too, so a mask write moves it together with the write answer.
   assign evt_mask_d = (wr_evt_mask && wr_strb_q[`CRI_STRB_FLAG]) ?
      wr_data_q[`CRI_EVT_MSB:`CRI_EVT_LSB] : evt_mask_q;

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_en_q <= ctrl_reset_image[`CRI_EN_MSB:`CRI_EN_LSB];
      end else if (wr_ctrl && wr_strb_q[`CRI_STRB_EN]) begin
         irq_en_q <= wr_data_q[`CRI_EN_MSB:`CRI_EN_LSB]; // [R1] [R2] [R3] [R4] [R5]
      end
   end

   // Flag bits ignore direct writes; only the clear bits affect them.
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ready_flag_q <= ctrl_reset_image[`CRI_FLAG_MSB:`CRI_FLAG_LSB];
      end else begin
         ready_flag_q <= ready_flag_d; // [R9]
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         clock_security_flag_q <= ctrl_reset_image[`CRI_CSS_FLAG_BIT];
      end else begin
         clock_security_flag_q <= clock_security_flag_d; // [R6] [R18]
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         evt_status_q <= `CRI_EVT_RESET;
      end else begin
         evt_status_q <= evt_status_d;
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         evt_mask_q <= `CRI_MASK_RESET;
      end else begin
         evt_mask_q <= evt_mask_d;
      end
   end

   // Both requests follow the next-state values so they rise with the flag, not a cycle later.
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         clock_irq_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         clock_irq_q <= (|ready_flag_d) || clock_security_flag_d; // [R19]
         irq_q <= |(evt_status_d & evt_mask_d);
      end
   end

   // Reserved bits 6:5 and the clear bits always read as zero.
   always_comb begin
      ctrl_view = '0;
      ctrl_view[`CRI_FLAG_MSB:`CRI_FLAG_LSB] = {pll_ready_flag, fast_ext_osc_ready_flag, fast_int_osc_ready_flag,
         slow_ext_osc_ready_flag, slow_int_osc_ready_flag};
      ctrl_view[`CRI_CSS_FLAG_BIT] = clock_security_flag_q;
      ctrl_view[`CRI_EN_MSB:`CRI_EN_LSB] = irq_en_q;
   end

   // Write address and data are taken independently, in either order.
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         aw_got_q <= 1'b0;
         wr_addr_q <= '0;
         awready_q <= 1'b0;
      end else if (awvalid_in && awready_q) begin
         aw_got_q <= 1'b1;
         wr_addr_q <= awaddr_in;
         awready_q <= 1'b0;
      end else if (wr_fire) begin
         aw_got_q <= 1'b0;
      end else if (wr_state_q == CRI_WR_IDLE && !aw_got_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         w_got_q <= 1'b0;
         wr_data_q <= '0;
         wr_strb_q <= '0;
         wready_q <= 1'b0;
      end else if (wvalid_in && wready_q) begin
         w_got_q <= 1'b1;
         wr_data_q <= wdata_in;
         wr_strb_q <= wstrb_in;
         wready_q <= 1'b0;
      end else if (wr_fire) begin
         w_got_q <= 1'b0;
      end else if (wr_state_q == CRI_WR_IDLE && !w_got_q) begin
         wready_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_state_q <= CRI_WR_IDLE;
         bvalid_q <= 1'b0;
         bresp_q <= `CRI_RESP_OKAY;
      end else begin
         case (wr_state_q)
            CRI_WR_IDLE: begin
               if (wr_fire) begin
                  bvalid_q <= 1'b1;
                  bresp_q <= is_mapped(wr_addr_q) ? `CRI_RESP_OKAY : `CRI_RESP_SLVERR;
                  wr_state_q <= CRI_WR_RESP;
               end
            end
            CRI_WR_RESP: begin
               if (bready_in) begin
                  bvalid_q <= 1'b0;
                  wr_state_q <= CRI_WR_IDLE;
               end
            end
            default: begin
               bvalid_q <= 1'b0;
               wr_state_q <= CRI_WR_IDLE;
            end
         endcase
      end
   end

   // Reads have no side effects on any flag.
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_state_q <= CRI_RD_IDLE;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= `CRI_RESP_OKAY;
         rdata_q <= '0;
      end else begin
         case (rd_state_q)
            CRI_RD_IDLE: begin
               if (arvalid_in && arready_q) begin
                  arready_q <= 1'b0;
                  rvalid_q <= 1'b1;
                  rresp_q <= is_mapped(araddr_in) ? `CRI_RESP_OKAY : `CRI_RESP_SLVERR;
                  case (araddr_in)
                     `CRI_OFF_CTRL: rdata_q <= ctrl_view;
                     `CRI_OFF_EVT_STS: rdata_q <= {{(`CRI_DATA_W-`CRI_NEVT){1'b0}}, evt_status_q};
                     `CRI_OFF_EVT_MASK: rdata_q <= {{(`CRI_DATA_W-`CRI_NEVT){1'b0}}, evt_mask_q};
                     default: rdata_q <= '0;
                  endcase
                  rd_state_q <= CRI_RD_RESP;
               end else begin
                  arready_q <= 1'b1;
               end
            end
            CRI_RD_RESP: begin
               if (rready_in) begin
                  rvalid_q <= 1'b0;
                  rd_state_q <= CRI_RD_IDLE;
               end
            end
            default: begin
               arready_q <= 1'b0;
               rvalid_q <= 1'b0;
               rd_state_q <= CRI_RD_IDLE;
            end
         endcase
      end
   end

   assign awready_out = awready_q;
   assign wready_out = wready_q;
   assign bvalid_out = bvalid_q;
   assign bresp_out = bresp_q;
   assign arready_out = arready_q;
   assign rvalid_out = rvalid_q;
   assign rresp_out = rresp_q;
   assign rdata_out = rdata_q;
   assign clock_irq_out = clock_irq_q;
   assign irq_out = irq_q;

endmodule

`default_nettype wire

// ==== dv/cri_monitor.sv ====
// Concurrent checks on the clock ready interrupt block's ports.
// Assumes it is bound to cri_top and sees only that module's ports.
`include "cri_defs.svh"
`default_nettype none

module cri_monitor (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Register bus.
   input wire logic awvalid_in,
   input wire logic awready_out,
   input wire logic wvalid_in,
   input wire logic wready_out,
   input wire logic [1:0] bresp_out,
   input wire logic bvalid_out,
   input wire logic bready_in,
   input wire logic [`CRI_ADDR_W-1:0] araddr_in,
   input wire logic arvalid_in,
   input wire logic arready_out,
   input wire logic [`CRI_DATA_W-1:0] rdata_out,
   input wire logic [1:0] rresp_out,
   input wire logic rvalid_out,
   input wire logic rready_in,
   // Status and interrupts.
   input wire cri_pkg::cri_src_t osc_status_in,
   input wire logic clock_irq_out,
   input wire logic irq_out
);
   import cri_pkg::*;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_wtake;
      awvalid_in && awready_out && wvalid_in && wready_out;
   endsequence
   sequence s_rtake;
      arvalid_in && arready_out;
   endsequence
   property p_wlat;
      s_wtake |=> !bvalid_out ##1 bvalid_out;
   endproperty
   a_wlat: assert property (p_wlat) else $error("write response not two cycles after request");
   property p_rlat;
      s_rtake |=> rvalid_out && !arready_out ##1 !arready_out;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read response timing wrong");
   property p_bhold;
      bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped before taken");
   property p_rhold;
      rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out) && $stable(rresp_out);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read response dropped before taken");
   property p_rerr;
      arvalid_in && arready_out && !(araddr_in inside {`CRI_OFF_CTRL, `CRI_OFF_EVT_STS, `CRI_OFF_EVT_MASK})
         |=> rresp_out == `CRI_RESP_SLVERR && rdata_out == 32'h0;
   endproperty
   a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
   property p_css;
      $rose(osc_status_in.css_fail) |-> ##[1:3] clock_irq_out;
   endproperty
   a_css: assert property (p_css) else $error("oscillator failure raised no request");
   property p_cfall;
      $fell(clock_irq_out) |-> bvalid_out;
   endproperty
   a_cfall: assert property (p_cfall) else $error("request dropped without a write");
   property p_ifall;
      $fell(irq_out) |-> bvalid_out;
   endproperty
   a_ifall: assert property (p_ifall) else $error("interrupt dropped without a write");
endmodule

bind cri_top cri_monitor u_cri_mon (.*);

`default_nettype wire

// ==== dv/cri_top_tb.sv ====
// Self-checking bench for the clock ready interrupt block through its AXI4-Lite slave.
// Assumes cri_top and cri_monitor are compiled before it.
`include "cri_defs.svh"
`default_nettype none

module cri_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cri_pkg::*;
   logic core_clk_in, reset_n_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
   logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, clock_irq_out, irq_out;
   logic [`CRI_ADDR_W-1:0] awaddr_in, araddr_in;
   logic [31:0] wdata_in, rdata_out;
   logic [3:0] wstrb_in;
   logic [1:0] bresp_out, rresp_out;
   cri_src_t osc_status_in;
   int miscompares = 0;
   int total_checks = 0;

   cri_top dut (.*);

   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chkb(input string nm, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %b seen %b", nm, exp, got);
      end
   endtask

   // A handshake that never completes ends the run at once.
   task automatic stuck(input logic timed_out);
      if (timed_out) begin
         miscompares++;
         $display("mismatch handshake expected done seen timeout");
         complete_run();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge core_clk_in);
      awaddr_in <= a;
      wdata_in <= d;
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      bready_in <= 1'b1;
      do begin
         @(posedge core_clk_in);
         n++;
         if (awready_out) awvalid_in <= 1'b0;
         if (wready_out) wvalid_in <= 1'b0;
      end while (bvalid_out !== 1'b1 && n < 40);
      bready_in <= 1'b0;
      stuck(bvalid_out !== 1'b1);
      chk("bresp", {30'h0, er}, {30'h0, bresp_out});
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
      int n;
      n = 0;
      @(posedge core_clk_in);
      araddr_in <= a;
      arvalid_in <= 1'b1;
      rready_in <= 1'b1;
      do begin
         @(posedge core_clk_in);
         n++;
         if (arready_out) arvalid_in <= 1'b0;
      end while (rvalid_out !== 1'b1 && n < 40);
      rready_in <= 1'b0;
      stuck(rvalid_out !== 1'b1);
      chk("rresp", {30'h0, er}, {30'h0, rresp_out});
      chk("rdata", ed, rdata_out);
   endtask

   // The flag lands three edges after the level rises, so four edges is enough.
   task automatic set_src(input int i, input logic v);
      @(posedge core_clk_in);
      osc_status_in[i] <= v;
      repeat (4) @(posedge core_clk_in);
   endtask

   initial begin
      logic [31:0] en;
      reset_n_in = 1'b0;
      {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 5'h00;
      awaddr_in = 8'h00;
      araddr_in = 8'h00;
      wdata_in = 32'h0;
      wstrb_in = 4'hf;
      osc_status_in = 6'h00;
      repeat (10) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      rd(`CRI_OFF_CTRL, `CRI_RESP_OKAY, 32'h0);
      rd(8'h40, `CRI_RESP_SLVERR, 32'h0);
      wr(8'h40, 32'h1f00, `CRI_RESP_SLVERR);
      wr(`CRI_OFF_CTRL, 32'h1f9f, `CRI_RESP_OKAY);
      rd(`CRI_OFF_CTRL, `CRI_RESP_OKAY, 32'h1f00);
      for (int i = 0; i < 5; i++) begin
         en = 32'h1f00 ^ (32'h100 << i);
         wr(`CRI_OFF_CTRL, en, `CRI_RESP_OKAY);
         set_src(i, 1'b1);
         rd(`CRI_OFF_CTRL, `CRI_RESP_OKAY, en);
         set_src(i, 1'b0);
         wr(`CRI_OFF_CTRL, 32'h1f00, `CRI_RESP_OKAY);
         set_src(i, 1'b1);
         rd(`CRI_OFF_CTRL, `CRI_RESP_OKAY, 32'h1f00 | (32'h1 << i));
         chkb("clock_irq", 1'b1, clock_irq_out);
         wr(`CRI_OFF_CTRL, 32'h1f00 | (32'h10000 << i), `CRI_RESP_OKAY);
         rd(`CRI_OFF_CTRL, `CRI_RESP_OKAY, 32'h1f00);
         chkb("clock_irq", 1'b0, clock_irq_out);
         set_src(i, 1'b0);
      end
      set_src(5, 1'b1);
      rd(`CRI_OFF_CTRL, `CRI_RESP_OKAY, 32'h1f80);
      wr(`CRI_OFF_CTRL, 32'h1f00, `CRI_RESP_OKAY);
      rd(`CRI_OFF_CTRL, `CRI_RESP_OKAY, 32'h1f80);
      wr(`CRI_OFF_CTRL, 32'h0080_1f00, `CRI_RESP_OKAY);
      rd(`CRI_OFF_CTRL, `CRI_RESP_OKAY, 32'h1f00);
      set_src(5, 1'b0);
      rd(`CRI_OFF_EVT_STS, `CRI_RESP_OKAY, 32'h3f);
      chkb("irq", 1'b0, irq_out);
      wr(`CRI_OFF_EVT_MASK, 32'h21, `CRI_RESP_OKAY);
      rd(`CRI_OFF_EVT_MASK, `CRI_RESP_OKAY, 32'h21);
      chkb("irq", 1'b1, irq_out);
      wr(`CRI_OFF_EVT_MASK, 32'h00, `CRI_RESP_OKAY);
      chkb("irq", 1'b0, irq_out);
      wr(`CRI_OFF_EVT_MASK, 32'h21, `CRI_RESP_OKAY);
      chkb("irq", 1'b1, irq_out);
      wr(`CRI_OFF_EVT_STS, 32'h21, `CRI_RESP_OKAY);
      rd(`CRI_OFF_EVT_STS, `CRI_RESP_OKAY, 32'h1e);
      chkb("irq", 1'b0, irq_out);
      complete_run();
   end
endmodule

`default_nettype wire
